/* include/sfspi_cfg.svh */
// constants of the serial flash spi front end
`ifndef SFSPI_CFG_SVH
`define SFSPI_CFG_SVH

// pin synchroniser: raw pins, reset values (all idle / released)
`define SFSPI_PIN_CNT        5
`define SFSPI_PIN_RST        5'h1_F
// pin positions inside the synchronised vector
`define SFSPI_PIN_CLK        0
`define SFSPI_PIN_SEL_N      1
`define SFSPI_PIN_DIN        2
`define SFSPI_PIN_CLR_N      3
`define SFSPI_PIN_FRZ_N      4

// byte framing
`define SFSPI_BYTE_W         8
`define SFSPI_CNT_W          3
`define SFSPI_CNT_RST        3'h0
`define SFSPI_BYTE_RST       8'h00
`define SFSPI_OUT_RST        1'b0

// default width of the protected-area size field
`define SFSPI_PSIZE_W        3

`endif

/* include/sfspi_pkg.sv */
// types of the serial flash spi front end
package sfspi_pkg;

  // link state: reset pin held, deselected, selected
  typedef enum logic [1:0] {
    SFSPI_ST_CLEAR,
    SFSPI_ST_IDLE,
    SFSPI_ST_SEL
  } sfspi_state_e;

endpackage : sfspi_pkg

/* hw/sfspi_sync.sv */
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
`include "sfspi_cfg.svh"

module sfspi_sync #(
  parameter int unsigned         W       = `SFSPI_PIN_CNT,
  parameter logic [W-1:0]        RST_VAL = `SFSPI_PIN_RST
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [W-1:0]      async_i,
  output logic      [W-1:0]      sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  if (W < 1)
  begin : g_bad_width
    $error("sfspi_sync: width must be at least one");
  end

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : sfspi_sync

/* hw/sfspi_frontend.sv */
// serial flash spi front end: pin sampling, framing, output drive, power state
//
// Overview of operation
// - launch each outgoing bit after a falling shift-clock edge.
// - sample serial_in on every rising shift-clock edge.
// - select pin high means deselected, serial_out released to high impedance.
// - deselected with no internal cycle running means standby power.
// - select pin low selects the device and enters active power.
// - no command accepted before the first select falling edge after power-up.
// - hard clear pin low holds reset mode with serial_out released.
// - hard clear pin high allows normal operation on the serial link.
// - hard clear during an internal cycle disturbs that cycle.
// - protect freeze pin low freezes the protected-area size.
// - only modes zero and three are served; in mode zero the code sends stale bits until the fall after the eighth rise.
// - modifying commands accepted only after a whole number of bytes.
`timescale 1ns/1ps
`include "sfspi_cfg.svh"

module sfspi_frontend #(
  parameter int unsigned              PSIZE_W = `SFSPI_PSIZE_W
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   shift_timing_i,
  input  wire logic                   device_select_n_i,
  input  wire logic                   serial_in_i,
  input  wire logic                   hard_clear_n_i,
  input  wire logic                   protect_freeze_n_i,
  output logic                        serial_out_o,
  output logic                        serial_out_oe_n_o,
  input  wire logic [`SFSPI_BYTE_W-1:0] tx_byte_i,
  output logic                        tx_taken_o,
  output logic [`SFSPI_BYTE_W-1:0]    rx_byte_o,
  output logic                        rx_valid_o,
  output logic                        frame_end_o,
  output logic                        frame_whole_o,
  input  wire logic                   busy_i,
  output logic                        active_power_o,
  output logic                        standby_o,
  output logic                        cycle_disturb_o,
  input  wire logic [PSIZE_W-1:0]     protect_size_i,
  output logic [PSIZE_W-1:0]          protect_size_o
);

  if (PSIZE_W < 1)
  begin : g_bad_psize
    $error("sfspi_frontend: protected-size width must be at least one");
  end

  // ----------------------------------------------------------------
  // pin synchronisation and edge finding
  // ----------------------------------------------------------------
  logic [`SFSPI_PIN_CNT-1:0] pins_s;
  logic [`SFSPI_PIN_CNT-1:0] pins_d_ff;

  sfspi_sync #(
    .W       (`SFSPI_PIN_CNT),
    .RST_VAL (`SFSPI_PIN_RST)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({protect_freeze_n_i, hard_clear_n_i, serial_in_i, device_select_n_i, shift_timing_i}),
    .sync_o    (pins_s)
  );

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pins_d_ff <= `SFSPI_PIN_RST;
    else
      pins_d_ff <= pins_s;
  end

  logic clk_rise, clk_fall, sel_fall, sel_rise, clr_s, frz_s, din_s, sel_n_s;
  // edge based; an idle-low clock has no fall before the first rise, so the first byte is fetched at the fall after the eighth rise
  assign clk_rise = pins_s[`SFSPI_PIN_CLK] & ~pins_d_ff[`SFSPI_PIN_CLK];
  assign clk_fall = ~pins_s[`SFSPI_PIN_CLK] & pins_d_ff[`SFSPI_PIN_CLK];
  assign sel_fall = ~pins_s[`SFSPI_PIN_SEL_N] & pins_d_ff[`SFSPI_PIN_SEL_N];
  assign sel_rise = pins_s[`SFSPI_PIN_SEL_N] & ~pins_d_ff[`SFSPI_PIN_SEL_N];
  assign sel_n_s  = pins_s[`SFSPI_PIN_SEL_N];
  assign din_s    = pins_s[`SFSPI_PIN_DIN];
  assign clr_s    = pins_s[`SFSPI_PIN_CLR_N];
  assign frz_s    = pins_s[`SFSPI_PIN_FRZ_N];

  // ----------------------------------------------------------------
  // link state and framing
  // ----------------------------------------------------------------
  sfspi_pkg::sfspi_state_e     state_ff, nxt_state;
  logic                        armed_ff, nxt_armed;
  logic [`SFSPI_CNT_W-1:0]     bit_cnt_ff, nxt_bit_cnt;
  logic [`SFSPI_BYTE_W-1:0]    rx_sh_ff, nxt_rx_sh;
  logic [`SFSPI_BYTE_W-1:0]    rx_byte_ff, nxt_rx_byte;
  logic                        rx_valid_ff, nxt_rx_valid;
  logic                        fend_ff, nxt_fend;
  logic                        fwhole_ff, nxt_fwhole;
  logic                        disturb_ff, nxt_disturb;
  logic                        clr_d_ff;

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_armed    = armed_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_rx_sh    = rx_sh_ff;
    nxt_rx_byte  = rx_byte_ff;
    nxt_rx_valid = 1'b0;
    nxt_fend     = 1'b0;
    nxt_fwhole   = fwhole_ff;
    // hard clear falling while an internal cycle runs
    nxt_disturb  = clr_d_ff & ~clr_s & busy_i;
    if (!clr_s)
    begin
      // reset mode: forget the frame and the arming edge
      nxt_state   = sfspi_pkg::SFSPI_ST_CLEAR;
      nxt_armed   = 1'b0;
      nxt_bit_cnt = `SFSPI_CNT_RST;
    end
    else
    begin
      unique case (state_ff)
        sfspi_pkg::SFSPI_ST_CLEAR:
          nxt_state = sfspi_pkg::SFSPI_ST_IDLE;
        sfspi_pkg::SFSPI_ST_IDLE:
          if (sel_fall)
          begin
            nxt_state   = sfspi_pkg::SFSPI_ST_SEL;
            nxt_armed   = 1'b1;
            nxt_bit_cnt = `SFSPI_CNT_RST;
          end
        sfspi_pkg::SFSPI_ST_SEL:
          if (sel_n_s)
          begin
            // deselect closes the frame; whole bytes only qualify
            nxt_state   = sfspi_pkg::SFSPI_ST_IDLE;
            nxt_fend    = sel_rise;
            nxt_fwhole  = (bit_cnt_ff == `SFSPI_CNT_RST);
            nxt_bit_cnt = `SFSPI_CNT_RST;
          end
          else if (clk_rise && armed_ff)
          begin
            nxt_rx_sh   = {rx_sh_ff[`SFSPI_BYTE_W-2:0], din_s};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7)
            begin
              nxt_rx_byte  = {rx_sh_ff[`SFSPI_BYTE_W-2:0], din_s};
              nxt_rx_valid = 1'b1;
            end
          end
        default:
          nxt_state = sfspi_pkg::SFSPI_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff    <= sfspi_pkg::SFSPI_ST_CLEAR;
      armed_ff    <= 1'b0;
      bit_cnt_ff  <= `SFSPI_CNT_RST;
      rx_sh_ff    <= `SFSPI_BYTE_RST;
      rx_byte_ff  <= `SFSPI_BYTE_RST;
      rx_valid_ff <= 1'b0;
      fend_ff     <= 1'b0;
      fwhole_ff   <= 1'b0;
      disturb_ff  <= 1'b0;
      clr_d_ff    <= 1'b1;
    end
    else
    begin
      state_ff    <= nxt_state;
      armed_ff    <= nxt_armed;
      bit_cnt_ff  <= nxt_bit_cnt;
      rx_sh_ff    <= nxt_rx_sh;
      rx_byte_ff  <= nxt_rx_byte;
      rx_valid_ff <= nxt_rx_valid;
      fend_ff     <= nxt_fend;
      fwhole_ff   <= nxt_fwhole;
      disturb_ff  <= nxt_disturb;
      clr_d_ff    <= clr_s;
    end
  end

  // ----------------------------------------------------------------
  // output shifter and driver
  // ----------------------------------------------------------------
  logic [`SFSPI_BYTE_W-1:0] tx_sh_ff, nxt_tx_sh;
  logic                     out_ff, nxt_out;
  logic                     oe_n_ff, nxt_oe_n;
  logic                     taken_ff, nxt_taken;

  always_comb
  begin
    nxt_tx_sh = tx_sh_ff;
    nxt_out   = out_ff;
    nxt_taken = 1'b0;
    // driven only while selected and out of reset mode
    nxt_oe_n  = ~(clr_s && state_ff == sfspi_pkg::SFSPI_ST_SEL && !sel_n_s);
    if (state_ff == sfspi_pkg::SFSPI_ST_SEL && !sel_n_s && armed_ff && clk_fall)
    begin
      // byte boundary: fetch the next byte, launch its top bit
      if (bit_cnt_ff == `SFSPI_CNT_RST)
      begin
        nxt_out   = tx_byte_i[`SFSPI_BYTE_W-1];
        nxt_tx_sh = {tx_byte_i[`SFSPI_BYTE_W-2:0], 1'b0};
        nxt_taken = 1'b1;
      end
      else
      begin
        nxt_out   = tx_sh_ff[`SFSPI_BYTE_W-1];
        nxt_tx_sh = {tx_sh_ff[`SFSPI_BYTE_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_sh_ff <= `SFSPI_BYTE_RST;
      out_ff   <= `SFSPI_OUT_RST;
      oe_n_ff  <= 1'b1;
      taken_ff <= 1'b0;
    end
    else
    begin
      tx_sh_ff <= nxt_tx_sh;
      out_ff   <= nxt_out;
      oe_n_ff  <= nxt_oe_n;
      taken_ff <= nxt_taken;
    end
  end

  // ----------------------------------------------------------------
  // protected-area size freeze
  // ----------------------------------------------------------------
  logic [PSIZE_W-1:0] psize_ff, nxt_psize;

  always_comb
  begin
    // tracks the status field only while the freeze pin is released
    nxt_psize = frz_s ? protect_size_i : psize_ff;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      psize_ff <= '0;
    else
      psize_ff <= nxt_psize;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign serial_out_o      = out_ff;
  assign serial_out_oe_n_o = oe_n_ff;
  assign tx_taken_o        = taken_ff;
  assign rx_byte_o         = rx_byte_ff;
  assign rx_valid_o        = rx_valid_ff;
  assign frame_end_o       = fend_ff;
  assign frame_whole_o     = fwhole_ff;
  assign cycle_disturb_o   = disturb_ff;
  assign protect_size_o    = psize_ff;
  // internal cycles keep the part in active power after deselect
  assign active_power_o    = (state_ff == sfspi_pkg::SFSPI_ST_SEL) | busy_i;
  assign standby_o         = (state_ff != sfspi_pkg::SFSPI_ST_SEL) & ~busy_i;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence sel_entry_s;
    sel_fall && clr_s && state_ff == sfspi_pkg::SFSPI_ST_IDLE;
  endsequence

  sequence sel_active_s;
    state_ff == sfspi_pkg::SFSPI_ST_SEL && active_power_o;
  endsequence

  out_launch_edge_a: assert property (
    $changed(serial_out_o) |-> $past(clk_fall))
    else $error("serial_out changed without a falling clock edge");

  in_sample_count_a: assert property (
    state_ff == sfspi_pkg::SFSPI_ST_SEL && armed_ff && clk_rise && !sel_n_s && clr_s
    |=> bit_cnt_ff == $past(bit_cnt_ff) + 3'h1)
    else $error("rising clock edge not counted");

  desel_release_a: assert property (
    sel_n_s |=> serial_out_oe_n_o)
    else $error("serial_out driven while deselected");

  idle_standby_a: assert property (
    state_ff == sfspi_pkg::SFSPI_ST_IDLE && !busy_i |-> standby_o && !active_power_o)
    else $error("deselected and idle but not in standby");

  select_active_a: assert property (
    sel_entry_s |=> sel_active_s)
    else $error("select did not enter active power");

  arm_before_rx_a: assert property (
    !armed_ff |=> !rx_valid_o[*2])
    else $error("byte received before first select edge");

  clear_release_a: assert property (
    !clr_s [*2] |=> serial_out_oe_n_o && state_ff == sfspi_pkg::SFSPI_ST_CLEAR)
    else $error("reset mode not held with output released");

  clear_disturb_a: assert property (
    $fell(clr_s) && busy_i |=> cycle_disturb_o ##1 !cycle_disturb_o)
    else $error("internal cycle not disturbed by hard clear");

  freeze_hold_a: assert property (
    !frz_s |=> $stable(protect_size_o))
    else $error("protected size moved while frozen");

  frame_whole_a: assert property (
    state_ff == sfspi_pkg::SFSPI_ST_SEL && sel_rise && clr_s
    |=> frame_end_o && frame_whole_o == ($past(bit_cnt_ff) == `SFSPI_CNT_RST))
    else $error("frame byte count not judged");

  desel_fresh_a: assert property (
    state_ff == sfspi_pkg::SFSPI_ST_SEL && sel_n_s |=> bit_cnt_ff == `SFSPI_CNT_RST)
    else $error("bit counter not cleared at deselect");

endmodule : sfspi_frontend

/* tb/sfspi_master.sv */
// spi bus master model driving the front end pins
`timescale 1ns/1ps

module sfspi_master (
  input  wire logic sys_clk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      sel_n_o,
  output logic      mosi_o
);
  initial
  begin
    sclk_o  = 1'b0;
    sel_n_o = 1'b1;
    mosi_o  = 1'b0;
  end

  // half a link clock: 4 system cycles, 800 ns period
  task automatic half();
    repeat (4) @(negedge sys_clk_i);
  endtask : half

  // one select window, msb first; the clock parks at the mode's idle level
  task automatic frame(input bit m3, input int nb, input logic [15:0] d, output logic [15:0] q);
    q = 16'h0000;
    sclk_o = m3;
    half();
    sel_n_o = 1'b0;
    half();
    for (int i = 0; i < nb; i++)
    begin
      sclk_o = 1'b0;
      mosi_o = d[15-i];
      half();
      q = {q[14:0], miso_i};
      sclk_o = 1'b1;
      half();
    end
    if (!m3)
      sclk_o = 1'b0;
    half();
    sel_n_o = 1'b1;
    // released data line must not show a stale bit
    mosi_o = ~mosi_o;
    half();
  endtask : frame
endmodule : sfspi_master

/* tb/sfspi_frontend_test.sv */
// self-checking bench of the serial flash spi front end
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module sfspi_frontend_test;
  logic       sys_clk_i;
  logic       rst_n_i;
  logic       sclk;
  logic       sel_n;
  logic       mosi;
  wire        miso;
  logic       hard_clear_n;
  logic       freeze_n;
  logic [7:0] tx_byte;
  logic       busy;
  logic [2:0] psize_in;
  logic       serial_out;
  logic       oe_n;
  logic       tx_taken;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       frame_end;
  logic       frame_whole;
  logic       active_pwr;
  logic       standby;
  logic       disturb;
  logic [2:0] psize_out;
  logic [7:0] rxq[$];
  logic [15:0] q;
  int         ends;
  int         disturbs;
  int         takes;
  int         miscompares;
  int         total_checks;

  // released line shows the inverse, so a late enable corrupts the sampled bits
  assign miso = (oe_n === 1'b0) ? serial_out : ~serial_out;

  sfspi_master mst (
    .sys_clk_i (sys_clk_i),
    .miso_i    (miso),
    .sclk_o    (sclk),
    .sel_n_o   (sel_n),
    .mosi_o    (mosi)
  );

  sfspi_frontend uut (
    .sys_clk_i          (sys_clk_i),
    .rst_n_i            (rst_n_i),
    .shift_timing_i     (sclk),
    .device_select_n_i  (sel_n),
    .serial_in_i        (mosi),
    .hard_clear_n_i     (hard_clear_n),
    .protect_freeze_n_i (freeze_n),
    .serial_out_o       (serial_out),
    .serial_out_oe_n_o  (oe_n),
    .tx_byte_i          (tx_byte),
    .tx_taken_o         (tx_taken),
    .rx_byte_o          (rx_byte),
    .rx_valid_o         (rx_valid),
    .frame_end_o        (frame_end),
    .frame_whole_o      (frame_whole),
    .busy_i             (busy),
    .active_power_o     (active_pwr),
    .standby_o          (standby),
    .cycle_disturb_o    (disturb),
    .protect_size_i     (psize_in),
    .protect_size_o     (psize_out)
  );

  // ----------------------------------------
  // clock, monitors, closing
  // ----------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // pulses last one cycle, so a falling-edge look sees each one settled
  always @(negedge sys_clk_i)
  begin
    if (rx_valid === 1'b1)
      rxq.push_back(rx_byte);
    if (frame_end === 1'b1)
      ends++;
    if (disturb === 1'b1)
      disturbs++;
    if (tx_taken === 1'b1)
      takes++;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    print_verdict();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic run(input bit m3, input int nb, input logic [15:0] d);
    rxq.delete();
    fork
      mst.frame(m3, nb, d, q);
      begin
        repeat (16) @(negedge sys_clk_i);
        `CHK("oe_n", 1'b0, oe_n)
        `CHK("active", 1'b1, active_pwr)
        `CHK("standby", 1'b0, standby)
      end
    join
  endtask : run

  task automatic t_reset();
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("standby", 1'b1, standby)
    `CHK("active", 1'b0, active_pwr)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_clear_arm();
    hard_clear_n = 1'b0;
    mst.sel_n_o = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    `CHK("oe_n", 1'b1, oe_n)
    hard_clear_n = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    rxq.delete();
    repeat (8)
    begin
      mst.sclk_o = 1'b1;
      mst.half();
      mst.sclk_o = 1'b0;
      mst.half();
    end
    `CHK("rx_cnt", 0, rxq.size())
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("disturb", 0, disturbs)
    mst.sel_n_o = 1'b1;
    mst.half();
    $display("t_clear_arm done");
  endtask : t_clear_arm

  task automatic t_mode0();
    int k0;
    k0 = takes;
    tx_byte = 8'hC3;
    run(1'b0, 16, 16'hA55A);
    `CHK("taken", k0 + 2, takes)
    `CHK("rx0", 8'hA5, rxq[0])
    `CHK("rx1", 8'h5A, rxq[1])
    `CHK("tx", 8'hC3, q[7:0])
    `CHK("whole", 1'b1, frame_whole)
    $display("t_mode0 done");
  endtask : t_mode0

  task automatic t_mode3();
    int k0;
    k0 = takes;
    tx_byte = 8'h96;
    run(1'b1, 8, 16'h3C00);
    `CHK("taken", k0 + 1, takes)
    `CHK("rx0", 8'h3C, rxq[0])
    `CHK("tx", 8'h96, q[7:0])
    `CHK("oe_n", 1'b1, oe_n)
    $display("t_mode3 done");
  endtask : t_mode3

  task automatic t_partial();
    int e0;
    e0 = ends;
    run(1'b0, 5, 16'hF800);
    `CHK("rx_cnt", 0, rxq.size())
    `CHK("whole", 1'b0, frame_whole)
    `CHK("ends", e0 + 1, ends)
    run(1'b0, 8, 16'h8100);
    `CHK("rx0", 8'h81, rxq[0])
    $display("t_partial done");
  endtask : t_partial

  task automatic t_busy();
    busy = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    `CHK("active", 1'b1, active_pwr)
    `CHK("standby", 1'b0, standby)
    hard_clear_n = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    `CHK("disturb", 1, disturbs)
    hard_clear_n = 1'b1;
    busy = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    `CHK("standby", 1'b1, standby)
    $display("t_busy done");
  endtask : t_busy

  task automatic t_freeze();
    psize_in = 3'h5;
    repeat (6) @(negedge sys_clk_i);
    `CHK("psize", 3'h5, psize_out)
    freeze_n = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    psize_in = 3'h2;
    repeat (4) @(negedge sys_clk_i);
    `CHK("psize", 3'h5, psize_out)
    freeze_n = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    `CHK("psize", 3'h2, psize_out)
    $display("t_freeze done");
  endtask : t_freeze

  initial
  begin
    rst_n_i = 1'b0;
    hard_clear_n = 1'b1;
    freeze_n = 1'b1;
    tx_byte = 8'h00;
    busy = 1'b0;
    psize_in = 3'h0;
    ends = 0;
    disturbs = 0;
    takes = 0;
    miscompares = 0;
    total_checks = 0;
    repeat (16) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    t_reset();
    t_clear_arm();
    t_mode0();
    t_mode3();
    t_partial();
    t_busy();
    t_freeze();
    print_verdict();
  end
endmodule : sfspi_frontend_test
